// ### hdl/orc_pkg.sv
// Purpose: Shared constants and types for the orientation classifier
// Assumes: 14-bit signed samples at 4096 counts per g
// Notes:   Threshold steps are about 2.9 mg (Z, X/Y) and 1.46 mg (front/back) per bit
package orc_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int SAMPLE_W = 14;
	localparam int MAG_W    = 14;
	localparam int LIM_W    = 16;
	localparam int TH_W     = 8;
	localparam int AXES     = 3;
	localparam int AX_X     = 0;
	localparam int AX_Y     = 1;
	localparam int AX_Z     = 2;

	// ----------------------------------------------------------------
	// Levels in counts
	// ----------------------------------------------------------------
	localparam logic [LIM_W-1:0] COUNTS_PER_G = 16'h1000;
	localparam logic [LIM_W-1:0] ZLIM_DEFAULT = 16'h0ccd;
	localparam logic [LIM_W-1:0] ZLIM_STEP    = 16'h000c;
	localparam logic [LIM_W-1:0] XY_STEP      = 16'h000c;
	localparam logic [LIM_W-1:0] FB_BASE      = 16'h02c9;
	localparam logic [LIM_W-1:0] FB_STEP      = 16'h0006;

	// ----------------------------------------------------------------
	// Result codes and reset values
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ORC_PL_UNKNOWN = 3'h0,
		ORC_PL_LEFT    = 3'h1,
		ORC_PL_RIGHT   = 3'h2,
		ORC_PL_DOWN    = 3'h5,
		ORC_PL_UP      = 3'h6
	} orc_pl_t;

	typedef enum logic [1:0] {
		ORC_FB_UNKNOWN  = 2'h0,
		ORC_FB_FRONT    = 2'h1,
		ORC_FB_BACK     = 2'h2,
		ORC_FB_RESERVED = 2'h3
	} orc_fb_t;

	localparam orc_pl_t    PL_RESET   = ORC_PL_UNKNOWN;
	localparam orc_fb_t    FB_RESET   = ORC_FB_UNKNOWN;
	localparam logic [5:0] DIR_RESET  = 6'h00;
	localparam logic       FLAG_RESET = 1'b0;

endpackage

// ### hdl/orc_mag_if.sv
// Purpose: Carries per-axis magnitude and sign between pipeline stages
// Assumes: Single clock domain
// Notes:   Index 0 is X, 1 is Y, 2 is Z
`timescale 1ns/100ps
interface orc_mag_if;
	import orc_pkg::*;
	logic                            valid;
	logic [AXES-1:0][MAG_W-1:0]      mag;
	logic [AXES-1:0]                 neg;
	modport src (output valid, output mag, output neg);
	modport dst (input valid, input mag, input neg);
endinterface

// ### hdl/orc_axis_mag.sv
// Purpose: Registers magnitude and sign of each axis sample
// Assumes: Samples come from logic on core_clk
// Notes:   Full-scale negative maps to its true magnitude
`timescale 1ns/100ps
module orc_axis_mag (
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	input  wire logic                         sample_valid,
	input  wire logic signed [orc_pkg::SAMPLE_W-1:0] x_sample,
	input  wire logic signed [orc_pkg::SAMPLE_W-1:0] y_sample,
	input  wire logic signed [orc_pkg::SAMPLE_W-1:0] z_sample,
	orc_mag_if.src                            mag_o
);
	import orc_pkg::*;

	// ----------------------------------------------------------------
	// Magnitude function
	// ----------------------------------------------------------------
	function automatic logic [MAG_W-1:0] orc_abs(input logic signed [SAMPLE_W-1:0] v);
		logic [SAMPLE_W-1:0] inv;
		inv = ~v;
		if (v[SAMPLE_W-1]) begin
			return MAG_W'(inv + 1'b1);
		end
		return MAG_W'(v);
	endfunction

	logic [AXES-1:0][SAMPLE_W-1:0] samp;
	logic [AXES-1:0][MAG_W-1:0]    mag_r;
	logic [AXES-1:0][MAG_W-1:0]    mag_nxt;
	logic [AXES-1:0]               neg_r;
	logic [AXES-1:0]               neg_nxt;
	logic                          valid_r;
	logic                          valid_nxt;

	assign samp[AX_X] = x_sample;
	assign samp[AX_Y] = y_sample;
	assign samp[AX_Z] = z_sample;

	// ----------------------------------------------------------------
	// Per-axis capture
	// ----------------------------------------------------------------
	for (genvar a = 0; a < AXES; a++) begin : g_axis
		always_comb begin
			mag_nxt[a] = mag_r[a];
			neg_nxt[a] = neg_r[a];
			if (sample_valid) begin
				mag_nxt[a] = orc_abs(samp[a]);
				neg_nxt[a] = samp[a][SAMPLE_W-1];
			end
		end
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				mag_r[a] <= '0;
				neg_r[a] <= 1'b0;
			end else begin
				mag_r[a] <= mag_nxt[a];
				neg_r[a] <= neg_nxt[a];
			end
		end
	end

	always_comb begin
		valid_nxt = sample_valid;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			valid_r <= FLAG_RESET;
		end else begin
			valid_r <= valid_nxt;
		end
	end

	assign mag_o.valid = valid_r;
	assign mag_o.mag   = mag_r;
	assign mag_o.neg   = neg_r;

endmodule

// ### hdl/orc_classifier.sv
// Purpose: Orientation classifier for a three-axis acceleration sensor
// Assumes: One sample_valid pulse per sampling period, thresholds static around it
// Notes:   Result appears two cycles after sample_valid
//
// Operation
// - Classify orientation every sample into status bits
// - Portrait/landscape from left, right, up, down
// - Default 45 degrees, Z magnitude below 0.8g
// - X/Y limits add offset, widen deadband
// - 0x00 gives 45 degrees, 0xFF about 15
// - Portrait and front/back offsets host programmable
// - Deadband reports portrait/landscape unknown
// - Z limits signed, 0x00 is 0.8g
// - Up/down from Z, X magnitude, X sign
// - Right/left from Z, Y magnitude, Y sign
// - Three-bit code, one direction at once
// - Front above threshold, back below its negative
// - Two-bit front/back code, 11 reserved
// - Fields refreshed each sample, never latched
`timescale 1ns/100ps
module orc_classifier (
	input  wire logic                                core_clk,
	input  wire logic                                rst_n,
	input  wire logic                                sample_valid,
	input  wire logic signed [orc_pkg::SAMPLE_W-1:0] x_sample,
	input  wire logic signed [orc_pkg::SAMPLE_W-1:0] y_sample,
	input  wire logic signed [orc_pkg::SAMPLE_W-1:0] z_sample,
	input  wire logic        [orc_pkg::TH_W-1:0]     updown_x_limit,
	input  wire logic        [orc_pkg::TH_W-1:0]     rightleft_y_limit,
	input  wire logic        [orc_pkg::TH_W-1:0]     updown_z_limit,
	input  wire logic        [orc_pkg::TH_W-1:0]     rightleft_z_limit,
	input  wire logic        [orc_pkg::TH_W-1:0]     frontback_z_limit,
	output logic             [2:0]                   portrait_landscape_code,
	output logic             [1:0]                   front_back_code,
	output logic                                     dir_up,
	output logic                                     dir_down,
	output logic                                     dir_left,
	output logic                                     dir_right,
	output logic                                     dir_front,
	output logic                                     dir_back,
	output logic                                     result_valid,
	output logic                                     pl_changed
);
	import orc_pkg::*;

	// ----------------------------------------------------------------
	// Threshold functions
	// ----------------------------------------------------------------
	function automatic logic [LIM_W-1:0] orc_zlimit(input logic [TH_W-1:0] off);
		logic signed [LIM_W-1:0] soff;
		logic signed [LIM_W-1:0] sum;
		soff = LIM_W'(signed'(off));
		sum  = signed'(ZLIM_DEFAULT) + LIM_W'(soff * signed'(ZLIM_STEP));
		return LIM_W'(sum);
	endfunction

	function automatic logic [LIM_W-1:0] orc_xylimit(input logic [MAG_W-1:0] other,
		input logic [TH_W-1:0] off);
		logic [LIM_W-1:0] uoff;
		uoff = LIM_W'(off);
		return LIM_W'(LIM_W'(other) + LIM_W'(uoff * XY_STEP));
	endfunction

	function automatic logic [LIM_W-1:0] orc_fblimit(input logic [TH_W-1:0] off);
		logic [LIM_W-1:0] uoff;
		uoff = LIM_W'(off);
		return LIM_W'(FB_BASE + LIM_W'(uoff * FB_STEP));
	endfunction

	function automatic logic orc_below(input logic [MAG_W-1:0] m, input logic [LIM_W-1:0] lim);
		return LIM_W'(m) < lim;
	endfunction

	function automatic logic orc_above(input logic [MAG_W-1:0] m, input logic [LIM_W-1:0] lim);
		return LIM_W'(m) > lim;
	endfunction

	// ----------------------------------------------------------------
	// Magnitude stage
	// ----------------------------------------------------------------
	orc_mag_if mag_bus ();

	orc_axis_mag u_mag (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.sample_valid (sample_valid),
		.x_sample     (x_sample),
		.y_sample     (y_sample),
		.z_sample     (z_sample),
		.mag_o        (mag_bus.src)
	);

	// ----------------------------------------------------------------
	// Axis views
	// ----------------------------------------------------------------
	logic [MAG_W-1:0] mag_x;
	logic [MAG_W-1:0] mag_y;
	logic [MAG_W-1:0] mag_z;
	logic             neg_x;
	logic             neg_y;
	logic             neg_z;

	assign mag_x = mag_bus.mag[AX_X];
	assign mag_y = mag_bus.mag[AX_Y];
	assign mag_z = mag_bus.mag[AX_Z];
	assign neg_x = mag_bus.neg[AX_X];
	assign neg_y = mag_bus.neg[AX_Y];
	assign neg_z = mag_bus.neg[AX_Z];

	// ----------------------------------------------------------------
	// Limits
	// ----------------------------------------------------------------
	logic [LIM_W-1:0] ud_z_lim;
	logic [LIM_W-1:0] rl_z_lim;
	logic [LIM_W-1:0] ud_x_lim;
	logic [LIM_W-1:0] rl_y_lim;
	logic [LIM_W-1:0] fb_lim;

	always_comb begin
		ud_z_lim = orc_zlimit(updown_z_limit);
		rl_z_lim = orc_zlimit(rightleft_z_limit);
		ud_x_lim = orc_xylimit(mag_y, updown_x_limit);
		rl_y_lim = orc_xylimit(mag_x, rightleft_y_limit);
		fb_lim   = orc_fblimit(frontback_z_limit);
	end

	// ----------------------------------------------------------------
	// Direction evaluation
	// ----------------------------------------------------------------
	logic             is_up;
	logic             is_down;
	logic             is_left;
	logic             is_right;
	logic             is_front;
	logic             is_back;
	logic             ud_ok;
	logic             rl_ok;

	always_comb begin
		ud_ok    = orc_below(mag_z, ud_z_lim) && orc_above(mag_x, ud_x_lim);
		rl_ok    = orc_below(mag_z, rl_z_lim) && orc_above(mag_y, rl_y_lim);
		is_up    = ud_ok && neg_x;
		is_down  = ud_ok && !neg_x;
		is_right = rl_ok && neg_y;
		is_left  = rl_ok && !neg_y;
		is_front = orc_above(mag_z, fb_lim) && !neg_z;
		is_back  = orc_above(mag_z, fb_lim) && neg_z;
	end

	// ----------------------------------------------------------------
	// Code selection
	// ----------------------------------------------------------------
	orc_pl_t pl_sel;
	orc_fb_t fb_sel;

	always_comb begin
		case ({is_left, is_right, is_down, is_up})
			4'h8:    pl_sel = ORC_PL_LEFT;
			4'h4:    pl_sel = ORC_PL_RIGHT;
			4'h2:    pl_sel = ORC_PL_DOWN;
			4'h1:    pl_sel = ORC_PL_UP;
			default: pl_sel = ORC_PL_UNKNOWN;
		endcase
		case ({is_back, is_front})
			2'h1:    fb_sel = ORC_FB_FRONT;
			2'h2:    fb_sel = ORC_FB_BACK;
			default: fb_sel = ORC_FB_UNKNOWN;
		endcase
	end

	// ----------------------------------------------------------------
	// Result registers
	// ----------------------------------------------------------------
	orc_pl_t    pl_r;
	orc_pl_t    pl_nxt;
	orc_fb_t    fb_r;
	orc_fb_t    fb_nxt;
	logic [5:0] dir_r;
	logic [5:0] dir_nxt;
	logic       valid_r;
	logic       valid_nxt;
	logic       chg_r;
	logic       chg_nxt;

	always_comb begin
		pl_nxt    = pl_r;
		fb_nxt    = fb_r;
		dir_nxt   = dir_r;
		valid_nxt = mag_bus.valid;
		chg_nxt   = 1'b0;
		if (mag_bus.valid) begin
			pl_nxt  = pl_sel;
			fb_nxt  = fb_sel;
			dir_nxt = {is_back, is_front, is_right, is_left, is_down, is_up};
			chg_nxt = (pl_sel != pl_r);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pl_r    <= PL_RESET;
			fb_r    <= FB_RESET;
			dir_r   <= DIR_RESET;
			valid_r <= FLAG_RESET;
			chg_r   <= FLAG_RESET;
		end else begin
			pl_r    <= pl_nxt;
			fb_r    <= fb_nxt;
			dir_r   <= dir_nxt;
			valid_r <= valid_nxt;
			chg_r   <= chg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign portrait_landscape_code = pl_r;
	assign front_back_code         = fb_r;
	assign dir_up                  = dir_r[0];
	assign dir_down                = dir_r[1];
	assign dir_left                = dir_r[2];
	assign dir_right               = dir_r[3];
	assign dir_front               = dir_r[4];
	assign dir_back                = dir_r[5];
	assign result_valid            = valid_r;
	assign pl_changed              = chg_r;

endmodule

// ### test/orc_host_model.sv
// Purpose: Host side model holding the last known orientation
// Assumes: Host polls after each result
// Notes:   One shared X/Y offset drives both limits
`timescale 1ns/100ps
module orc_host_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       result_valid,
	input  wire logic [2:0] portrait_landscape_code,
	input  wire logic [7:0] xy_cfg,
	output logic      [7:0] updown_x_limit,
	output logic      [7:0] rightleft_y_limit,
	output logic      [2:0] last_pl
);
	// ----------------------------------------------------------------
	// Limits and last known result
	// ----------------------------------------------------------------
	assign updown_x_limit = xy_cfg;
	assign rightleft_y_limit = xy_cfg;
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			last_pl <= 3'h0;
		else if (result_valid && portrait_landscape_code != 3'h0)
			last_pl <= portrait_landscape_code;
	end
endmodule

// ### test/orc_classifier_assertions.sv
// Purpose: Port checks of the classifier
// Assumes: Bound to orc_classifier
// Notes:   Result two cycles after the sample
`timescale 1ns/100ps
module orc_chk (
	input wire logic                                core_clk,
	input wire logic                                rst_n,
	input wire logic                                sample_valid,
	input wire logic signed [orc_pkg::SAMPLE_W-1:0] x_sample,
	input wire logic signed [orc_pkg::SAMPLE_W-1:0] y_sample,
	input wire logic signed [orc_pkg::SAMPLE_W-1:0] z_sample,
	input wire logic        [2:0]                   portrait_landscape_code,
	input wire logic        [1:0]                   front_back_code,
	input wire logic                                dir_up,
	input wire logic                                dir_down,
	input wire logic                                dir_left,
	input wire logic                                dir_right,
	input wire logic                                dir_front,
	input wire logic                                dir_back,
	input wire logic                                result_valid,
	input wire logic                                pl_changed
);
	import orc_pkg::*;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_take;
		sample_valid ##2 result_valid;
	endsequence
	chk_answer_two: assert property (sample_valid |-> s_take)
		else $error("result missing two cycles after sample");
	chk_no_spurious: assert property (result_valid |-> $past(sample_valid, 2))
		else $error("result without sample");
	chk_up_code: assert property (dir_up && !dir_down && !dir_left && !dir_right |-> portrait_landscape_code == 3'h6)
		else $error("up code wrong");
	chk_dead_unknown: assert property (!$onehot({dir_up, dir_down, dir_left, dir_right}) |-> portrait_landscape_code == 3'h0)
		else $error("deadband not unknown");
	chk_fb_code: assert property (front_back_code == {dir_back && !dir_front, dir_front && !dir_back})
		else $error("front/back code wrong");
	chk_codes_stand: assert property (!result_valid |-> $stable(portrait_landscape_code) && $stable(front_back_code))
		else $error("code moved without result");
	chk_change_pulse: assert property (pl_changed == (result_valid && portrait_landscape_code != $past(portrait_landscape_code)))
		else $error("change pulse wrong");
	chk_up_sign: assert property (result_valid && dir_up |-> $past(x_sample[SAMPLE_W-1], 2))
		else $error("up with positive X");
	chk_right_sign: assert property (result_valid && dir_right |-> $past(y_sample[SAMPLE_W-1], 2))
		else $error("right with positive Y");
	chk_front_sign: assert property (result_valid && dir_front |-> !$past(z_sample[SAMPLE_W-1], 2))
		else $error("front with negative Z");
endmodule
bind orc_classifier orc_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .sample_valid(sample_valid),
	.x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample),
	.portrait_landscape_code(portrait_landscape_code), .front_back_code(front_back_code),
	.dir_up(dir_up), .dir_down(dir_down), .dir_left(dir_left), .dir_right(dir_right),
	.dir_front(dir_front), .dir_back(dir_back), .result_valid(result_valid), .pl_changed(pl_changed));

// ### test/tb.sv
// Purpose: Self-checking bench of the classifier
// Assumes: One clock, 50 ns period
// Notes:   Expected results queued per sample
`timescale 1ns/100ps
module tb;
	import orc_pkg::*;
	logic                       core_clk = 1'b0;
	logic                       rst_n = 1'b0;
	logic                       sample_valid = 1'b0;
	logic signed [SAMPLE_W-1:0] x_s = '0, y_s = '0, z_s = '0;
	logic        [TH_W-1:0]     xy = '0, uz = '0, rz = '0, fbl = '0, udx, rly;
	logic        [2:0]          pl, last_pl, prev_pl = 3'h0;
	logic        [1:0]          fb;
	logic                       d_u, d_d, d_l, d_r, d_f, d_b, rv, chg;
	logic        [4:0]          e;
	logic        [4:0]          expq[$];
	int                         n_fail = 0, comparisons = 0;
	// ----------------------------------------------------------------
	// Clock, parts and tasks
	// ----------------------------------------------------------------
	always #25 core_clk = ~core_clk;
	orc_classifier u_dut (.core_clk(core_clk), .rst_n(rst_n), .sample_valid(sample_valid),
		.x_sample(x_s), .y_sample(y_s), .z_sample(z_s), .updown_x_limit(udx), .rightleft_y_limit(rly),
		.updown_z_limit(uz), .rightleft_z_limit(rz), .frontback_z_limit(fbl), .portrait_landscape_code(pl),
		.front_back_code(fb), .dir_up(d_u), .dir_down(d_d), .dir_left(d_l), .dir_right(d_r),
		.dir_front(d_f), .dir_back(d_b), .result_valid(rv), .pl_changed(chg));
	orc_host_model u_host (.core_clk(core_clk), .rst_n(rst_n), .result_valid(rv),
		.portrait_landscape_code(pl), .xy_cfg(xy), .updown_x_limit(udx), .rightleft_y_limit(rly), .last_pl(last_pl));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [4:0] expect_fn(input int x, y, z);
		int ax, ay, az, lvl;
		logic u, r;
		ax = x < 0 ? -x : x;
		ay = y < 0 ? -y : y;
		az = z < 0 ? -z : z;
		lvl = 713 + int'(fbl) * 6;
		u = az < 3277 + int'($signed(uz)) * 12 && ax > ay + int'(xy) * 12;
		r = az < 3277 + int'($signed(rz)) * 12 && ay > ax + int'(xy) * 12;
		expect_fn[1:0] = {z < 0 && az > lvl, z >= 0 && az > lvl};
		expect_fn[4:2] = (u && r) ? 3'h0 : u ? (x < 0 ? 3'h6 : 3'h5) : r ? (y < 0 ? 3'h2 : 3'h1) : 3'h0;
	endfunction
	task automatic send(input int x, y, z);
		@(posedge core_clk);
		sample_valid <= 1'b1;
		x_s <= x[SAMPLE_W-1:0];
		y_s <= y[SAMPLE_W-1:0];
		z_s <= z[SAMPLE_W-1:0];
		expq.push_back(expect_fn(x, y, z));
	endtask
	task automatic idle(input int n);
		@(posedge core_clk);
		sample_valid <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask
	task automatic lim(input logic [7:0] a, b, c, d, input string s);
		idle(3);
		$display("Test %s finished", s);
		xy <= a;
		uz <= b;
		rz <= c;
		fbl <= d;
	endtask
	always @(negedge core_clk) begin
		if (rv === 1'b1) begin
			e = expq.pop_front();
			check({3'h0, pl, fb}, {3'h0, e});
			check({7'h0, chg}, {7'h0, e[4:2] != prev_pl});
			check({2'h0, d_b, d_f, d_r, d_l, d_d, d_u}, {2'h0, e[1:0], e[4:2] == 3'h2, e[4:2] == 3'h1, e[4:2] == 3'h5, e[4:2] == 3'h6});
			prev_pl = e[4:2];
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		lim(8'h00, 8'h00, 8'h00, 8'h00, "reset");
		send(-4096, 0, 0);
		send(4096, 0, 0);
		send(0, -4096, 0);
		send(0, 4096, 0);
		send(-8192, 0, 0);
		send(2000, -2000, 0);
		send(-4096, 0, 3276);
		send(-4096, 0, 3277);
		send(0, 0, 713);
		send(0, 0, 714);
		send(0, 0, -714);
		lim(8'h00, 8'h80, 8'h80, 8'h00, "defaults");
		send(-4096, 0, 1740);
		send(-4096, 0, 1741);
		send(0, -4096, 1740);
		lim(8'h00, 8'h7f, 8'h7f, 8'h00, "low z limit");
		send(-4096, 0, 4800);
		send(0, 4096, 4801);
		lim(8'hff, 8'h00, 8'h00, 8'hff, "high z limit");
		send(-4096, 1035, 0);
		send(-4096, 1036, 0);
		send(1035, 4096, 0);
		send(0, 0, 2244);
		send(0, 0, 2243);
		send(0, 0, -2244);
		lim(8'h00, 8'h00, 8'h00, 8'h00, "offsets");
		send(0, 4096, 0);
		send(0, 0, 0);
		idle(4);
		check({5'h0, last_pl}, 8'h01);
		check(8'(expq.size()), 8'h00);
		$display("Test host finished");
		give_verdict();
	end
	initial begin
		repeat (2000) @(posedge core_clk);
		n_fail++;
		give_verdict();
	end
endmodule
